/* logic/drc_defs.vh */
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH
// s-curve time, 0.1 s units
`define DRC_SCURVE_MAX 12'hBB8
`define DRC_SCURVE_RST 12'h000
// slip setting, 0.1 Hz units; adder in 0.01 Hz units
`define DRC_SLIP_MAX 6'h32
`define DRC_SLIP_RST 6'h14
`define DRC_SLIP_ADD_MAX 10'h1F4
// stator drop boost, percent
`define DRC_BOOST_MAX 8'h96
// boost ceiling in 0.1 V units: 31.0 V and 15.5 V
`define DRC_BOOST_V460 9'h136
`define DRC_BOOST_V230 9'h09B
// thresholds
`define DRC_FREQ_THR_MAX 9'h190
`define DRC_CURR_THR_MAX 8'h96
// carrier in 0.1 kHz units when long leads are selected
`define DRC_CARRIER_LONG 8'h14
// output condition select codes
`define DRC_SEL_SPEED 3'h0
`define DRC_SEL_FREQ 3'h1
`define DRC_SEL_RUN 3'h2
`define DRC_SEL_FAULT 3'h3
`define DRC_SEL_ALARM 3'h4
`define DRC_SEL_CURR 3'h5
`define DRC_OUT1_RST 3'h3
`define DRC_OUT2_RST 3'h2
`endif

/* logic/drc_top.v */
`timescale 1ns/1ps
// Functional notes
// - s-curve time 0 to 300.0 s, default 0
// - s-curve time used only when shaping enabled
// - ramps lengthened by s-curve time
// - s-curve stop with stop command doubles set decel time, s-curve time not added
// - long leads fix 2 kHz carrier, ring-up reduction
// - slip correction added, default 2.0, max 5.0
// - zero slip setting disables slip correction
// - applied slip readable, 0.01 Hz, 0-5 Hz
// - stator boost max 31 V or 15.5 V
// - boost setting 0-150 %, zero disables
// - relay output selectable, default faulted
// - open collector selectable, default running
// - speed reached closes when output meets command
// - frequency above threshold closes output
// - running closes output
// - fault closes output
// - alarm from five listed conditions closes output
// - current above threshold closes output
// - frequency threshold 0-400 Hz, locked while running
// - current threshold 0-150 percent
`include "drc_defs.vh"
module drc_top (
	input wire CLK_SYS,
	input wire RST_N,
	input wire CFG_WE,
	input wire [11:0] SCURVE_TIME_IN,
	input wire SCURVE_EN,
	input wire [11:0] ACCEL_TIME,
	input wire [11:0] DECEL_TIME,
	input wire STOP_SCURVE,
	input wire STOP_CMD,
	input wire LEAD_LONG_IN,
	input wire [5:0] SLIP_SET_IN,
	input wire [7:0] TORQUE_CURR,
	input wire [7:0] BOOST_SET_IN,
	input wire UNIT_460V,
	input wire [2:0] OUT1_SEL_IN,
	input wire [2:0] OUT2_SEL_IN,
	input wire [8:0] FREQ_THR_IN,
	input wire [7:0] CURR_THR_IN,
	input wire [8:0] FREQ_CMD,
	input wire [8:0] FREQ_OUT,
	input wire [7:0] CURR_OUT,
	input wire RUNNING,
	input wire FAULT,
	input wire HW_ILIM,
	input wire SW_ILIM,
	input wire OVERVOLT,
	input wire LINE_LOSS,
	input wire LOOP_LOSS,
	output reg [12:0] ACCEL_EFF,
	output reg [13:0] DECEL_EFF,
	output reg [7:0] CARRIER_SET,
	output reg CARRIER_FIXED,
	output reg RINGUP_REDUCE,
	output reg [9:0] SLIP_ADDER,
	output reg [8:0] BOOST_VOLT,
	output reg RELAY_CLOSED,
	output reg OC_CLOSED,
	output wire [11:0] SCURVE_TIME,
	output wire [5:0] SLIP_SET,
	output wire [7:0] BOOST_SET,
	output wire [8:0] FREQ_THR,
	output wire [7:0] CURR_THR,
	output wire [2:0] OUT1_SEL,
	output wire [2:0] OUT2_SEL,
	output wire LEAD_LONG
);
	reg [11:0] scurve_reg;
	reg [5:0] slip_reg;
	reg [7:0] boost_reg;
	reg [8:0] fthr_reg;
	reg [7:0] cthr_reg;
	reg [2:0] sel1_reg;
	reg [2:0] sel2_reg;
	reg lead_reg;
	reg [12:0] accel_next;
	reg [13:0] decel_next;
	reg [13:0] decel_base;
	reg [9:0] slip_next;
	reg [17:0] slip_prod;
	reg [8:0] boost_next;
	reg [24:0] boost_prod;
	reg [8:0] boost_cap;
	wire alarm_any;
	wire [5:0] cond_vec;
	wire [1:0] out_vec;

	// evaluates one selected output condition
	function sel_cond;
		input [2:0] sel;
		input [5:0] cv;
		begin
			case (sel)
				`DRC_SEL_SPEED: sel_cond = cv[0];
				`DRC_SEL_FREQ: sel_cond = cv[1];
				`DRC_SEL_RUN: sel_cond = cv[2];
				`DRC_SEL_FAULT: sel_cond = cv[3];
				`DRC_SEL_ALARM: sel_cond = cv[4];
				`DRC_SEL_CURR: sel_cond = cv[5];
				default: sel_cond = 1'b0;
			endcase
		end
	endfunction

	// settings; out-of-range writes are dropped whole rather than clipped
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			scurve_reg <= `DRC_SCURVE_RST;
			slip_reg <= `DRC_SLIP_RST;
			boost_reg <= 8'h00;
			fthr_reg <= 9'h000;
			cthr_reg <= 8'h00;
			sel1_reg <= `DRC_OUT1_RST;
			sel2_reg <= `DRC_OUT2_RST;
			lead_reg <= 1'b0;
		end else if (CFG_WE) begin
			if (SCURVE_TIME_IN <= `DRC_SCURVE_MAX)
				scurve_reg <= SCURVE_TIME_IN;
			if (SLIP_SET_IN <= `DRC_SLIP_MAX)
				slip_reg <= SLIP_SET_IN;
			if (BOOST_SET_IN <= `DRC_BOOST_MAX)
				boost_reg <= BOOST_SET_IN;
			if (!RUNNING && FREQ_THR_IN <= `DRC_FREQ_THR_MAX)
				fthr_reg <= FREQ_THR_IN;
			if (CURR_THR_IN <= `DRC_CURR_THR_MAX)
				cthr_reg <= CURR_THR_IN;
			if (OUT1_SEL_IN <= `DRC_SEL_CURR)
				sel1_reg <= OUT1_SEL_IN;
			if (OUT2_SEL_IN <= `DRC_SEL_CURR)
				sel2_reg <= OUT2_SEL_IN;
			lead_reg <= LEAD_LONG_IN;
		end
	end

	// ramp times; operator keeps s-curve time within ramp times, not checked
	always @* begin
		accel_next = {1'b0, ACCEL_TIME};
		decel_base = {2'b00, DECEL_TIME};
		if (SCURVE_EN) begin
			accel_next = {1'b0, ACCEL_TIME} + {1'b0, scurve_reg};
			decel_base = {2'b00, DECEL_TIME} + {2'b00, scurve_reg};
		end
		decel_next = decel_base;
		if (STOP_SCURVE && STOP_CMD)
			decel_next = {DECEL_TIME, 1'b0} + 14'h0000;
	end

	// compensation: torque current scales setting; full scale is 8'hFF
	always @* begin
		slip_prod = {12'h000, slip_reg} * {10'h000, TORQUE_CURR};
		slip_next = slip_prod[17:8] * 10'h00A; // 0.1 Hz to 0.01 Hz
		if (slip_reg == 6'h00)
			slip_next = 10'h000;
		else if (slip_next > `DRC_SLIP_ADD_MAX)
			slip_next = `DRC_SLIP_ADD_MAX;
		boost_cap = UNIT_460V ? `DRC_BOOST_V460 : `DRC_BOOST_V230;
		boost_prod = {16'h0000, boost_cap} * {17'h00000, boost_reg} * {17'h00000, TORQUE_CURR};
		boost_next = boost_prod[24:16];
		if (boost_next > boost_cap)
			boost_next = boost_cap;
		if (boost_reg == 8'h00)
			boost_next = 9'h000;
	end

	assign alarm_any = HW_ILIM | SW_ILIM | OVERVOLT | LINE_LOSS | LOOP_LOSS;
	assign cond_vec[0] = (FREQ_OUT >= FREQ_CMD);
	assign cond_vec[1] = (FREQ_OUT > fthr_reg);
	assign cond_vec[2] = RUNNING;
	assign cond_vec[3] = FAULT;
	assign cond_vec[4] = alarm_any;
	assign cond_vec[5] = (CURR_OUT > cthr_reg);

	// one evaluator per output
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_out
			assign out_vec[gi] = sel_cond(gi == 0 ? sel1_reg : sel2_reg, cond_vec);
		end
	endgenerate

	// registered results, refreshed every cycle; power transitions are outside this logic
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ACCEL_EFF <= 13'h0000;
			DECEL_EFF <= 14'h0000;
			CARRIER_SET <= 8'h00;
			CARRIER_FIXED <= 1'b0;
			RINGUP_REDUCE <= 1'b0;
			SLIP_ADDER <= 10'h000;
			BOOST_VOLT <= 9'h000;
			RELAY_CLOSED <= 1'b0;
			OC_CLOSED <= 1'b0;
		end else begin
			ACCEL_EFF <= accel_next;
			DECEL_EFF <= decel_next;
			CARRIER_SET <= lead_reg ? `DRC_CARRIER_LONG : 8'h00;
			CARRIER_FIXED <= lead_reg;
			RINGUP_REDUCE <= lead_reg;
			SLIP_ADDER <= slip_next;
			BOOST_VOLT <= boost_next;
			RELAY_CLOSED <= out_vec[0];
			OC_CLOSED <= out_vec[1];
		end
	end

	assign SCURVE_TIME = scurve_reg;
	assign SLIP_SET = slip_reg;
	assign BOOST_SET = boost_reg;
	assign FREQ_THR = fthr_reg;
	assign CURR_THR = cthr_reg;
	assign OUT1_SEL = sel1_reg;
	assign OUT2_SEL = sel2_reg;
	assign LEAD_LONG = lead_reg;
endmodule

/* testbench/drc_properties.sv */
`timescale 1ns/1ps
module drc_props (
	input wire CLK_SYS, RST_N, RUNNING, FAULT, SCURVE_EN, LEAD_LONG, UNIT_460V,
	input wire RELAY_CLOSED, OC_CLOSED, CARRIER_FIXED, RINGUP_REDUCE,
	input wire [2:0] OUT1_SEL, OUT2_SEL,
	input wire [5:0] SLIP_SET,
	input wire [7:0] BOOST_SET, CARRIER_SET,
	input wire [8:0] BOOST_VOLT, FREQ_THR,
	input wire [9:0] SLIP_ADDER,
	input wire [11:0] ACCEL_TIME,
	input wire [12:0] ACCEL_EFF
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	chk_relay_run: assert property (OUT1_SEL == 3'h2 |=> RELAY_CLOSED == $past(RUNNING))
	else $error("relay off run");
	chk_oc_fault: assert property (OUT2_SEL == 3'h3 |=> OC_CLOSED == $past(FAULT))
	else $error("oc off fault");
	chk_long_lead: assert property (LEAD_LONG |=> CARRIER_FIXED && RINGUP_REDUCE && CARRIER_SET == 8'h14)
	else $error("long lead");
	chk_slip_off: assert property (SLIP_SET == 6'h0 |=> SLIP_ADDER == 10'h0)
	else $error("slip on");
	chk_boost_off: assert property (BOOST_SET == 8'h0 |=> BOOST_VOLT == 9'h0)
	else $error("boost on");
	chk_boost_cap: assert property (BOOST_VOLT <= 9'h136)
	else $error("boost cap");
	chk_boost_low: assert property (!UNIT_460V |=> BOOST_VOLT <= 9'h09B)
	else $error("boost cap low");
	chk_accel_plain: assert property (!SCURVE_EN |=> ACCEL_EFF == $past(ACCEL_TIME))
	else $error("accel");
	chk_thr_locked: assert property (RUNNING |=> $stable(FREQ_THR))
	else $error("thr moved");
	cover property (OUT1_SEL == 3'h4 && RELAY_CLOSED);
	cover property (LEAD_LONG && CARRIER_FIXED);
	cover property (SLIP_ADDER != 10'h0);
endmodule
bind drc_top drc_props i_drc_props (.*);

/* testbench/drc_ctl_model.sv */
`timescale 1ns/1ps
// far-side controller; blind while the drive settles, then counts cycles with either output closed
module drc_ctl_model #(parameter SETTLE = 8) (
	input wire clk,
	input wire rst_n,
	input wire relay,
	input wire oc,
	output logic [15:0] closes
);
	logic [15:0] age;
	// outputs are untrusted until the settle window has run out
	always @(posedge clk) begin
		if (!rst_n) begin
			age <= 16'h0;
			closes <= 16'h0;
		end else if (age < SETTLE) begin
			age <= age + 16'h1;
		end else begin
			closes <= closes + {15'h0, relay | oc};
		end
	end
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic CLK_SYS = '0, RST_N = '0, CFG_WE = '0, SCURVE_EN = '0, STOP_SCURVE = '0, STOP_CMD = '0;
	logic LEAD_LONG_IN = '0, UNIT_460V = '0, RUNNING = '0, FAULT = '0, HW_ILIM = '0;
	logic SW_ILIM = '0, OVERVOLT = '0, LINE_LOSS = '0, LOOP_LOSS = '0;
	logic [11:0] SCURVE_TIME_IN = '0, ACCEL_TIME = '0, DECEL_TIME = '0, es = '0;
	logic [7:0] TORQUE_CURR = '0, BOOST_SET_IN = '0, CURR_THR_IN = '0, CURR_OUT = '0, ec = '0;
	logic [7:0] eb = '0;
	logic [8:0] FREQ_THR_IN = '0, FREQ_CMD = '0, FREQ_OUT = '0, ef = '0;
	logic [2:0] OUT1_SEL_IN = 3'h3, OUT2_SEL_IN = 3'h2, e1 = 3'h3, e2 = 3'h2;
	logic [5:0] SLIP_SET_IN = 6'h14, ep = 6'h14;
	logic el = '0;
	logic [31:0] r, q;
	wire [12:0] ACCEL_EFF;
	wire [13:0] DECEL_EFF;
	wire [7:0] CARRIER_SET, BOOST_SET, CURR_THR;
	wire CARRIER_FIXED, RINGUP_REDUCE, RELAY_CLOSED, OC_CLOSED, LEAD_LONG;
	wire [9:0] SLIP_ADDER;
	wire [8:0] BOOST_VOLT, FREQ_THR;
	wire [11:0] SCURVE_TIME;
	wire [5:0] SLIP_SET;
	wire [2:0] OUT1_SEL, OUT2_SEL;
	int failures = 0, total_checks = 0;
	always #25 CLK_SYS = ~CLK_SYS;
	drc_top i_drc_top (.*);
	drc_ctl_model i_drc_ctl_model (.clk(CLK_SYS), .rst_n(RST_N), .relay(RELAY_CLOSED),
		.oc(OC_CLOSED), .closes());
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// expected level of an output for a select code
	function logic cond(input logic [2:0] s);
		case (s)
			3'h0: cond = FREQ_OUT >= FREQ_CMD;
			3'h1: cond = FREQ_OUT > ef;
			3'h2: cond = RUNNING;
			3'h3: cond = FAULT;
			3'h4: cond = HW_ILIM | SW_ILIM | OVERVOLT | LINE_LOSS | LOOP_LOSS;
			default: cond = CURR_OUT > ec;
		endcase
	endfunction
	// expected boost: setting times torque share of the unit's ceiling, then capped
	function logic [8:0] boost_exp(input logic u, input logic [7:0] b, input logic [7:0] t);
		logic [24:0] p;
		logic [8:0] cap;
		cap = u ? 9'h136 : 9'h09B;
		p = (25'(cap) * b * t) >> 16;
		boost_exp = (p > 25'(cap)) ? cap : p[8:0];
	endfunction
	// hang guard, well beyond the 600 cycles the loop needs
	initial begin
		#(50 * 3000);
		failures++;
		tally_and_finish;
	end
	// random writes include refused codes and out-of-range fields on purpose
	initial begin
		r = $urandom(32'hC52A);
		repeat (3) @(posedge CLK_SYS);
		RST_N <= 1'h1;
		@(posedge CLK_SYS);
		#1;
		chk(OUT1_SEL, 3'h3);
		chk(OUT2_SEL, 3'h2);
		chk(SCURVE_TIME, 12'h0);
		chk(LEAD_LONG, 1'h0);
		repeat (200) begin
			@(posedge CLK_SYS);
			r = $urandom;
			q = $urandom;
			{LEAD_LONG_IN, RUNNING, CURR_THR_IN, FREQ_THR_IN, OUT2_SEL_IN, OUT1_SEL_IN} <= r[24:0];
			{BOOST_SET_IN, SLIP_SET_IN, SCURVE_TIME_IN} <= q[25:0];
			CFG_WE <= 1'h1;
			if (r[2:0] < 6) e1 = r[2:0];
			if (r[5:3] < 6) e2 = r[5:3];
			if (r[14:6] <= 400 && !r[23]) ef = r[14:6];
			if (r[22:15] <= 150) ec = r[22:15];
			if (q[11:0] <= 3000) es = q[11:0];
			if (q[17:12] <= 50) ep = q[17:12];
			if (q[25:18] <= 150) eb = q[25:18];
			el = r[24];
			@(posedge CLK_SYS);
			r = $urandom;
			q = $urandom;
			CFG_WE <= 1'h0;
			{RUNNING, FAULT, HW_ILIM, SW_ILIM, OVERVOLT, LINE_LOSS, LOOP_LOSS} <= r[6:0];
			{FREQ_CMD, FREQ_OUT, CURR_OUT} <= {r[31:7], q[0]};
			{UNIT_460V, STOP_CMD, STOP_SCURVE, SCURVE_EN, DECEL_TIME, ACCEL_TIME} <= q[28:1];
			TORQUE_CURR <= $urandom;
			@(posedge CLK_SYS);
			#1;
			chk(OUT1_SEL, e1);
			chk(OUT2_SEL, e2);
			chk(FREQ_THR, ef);
			chk(CURR_THR, ec);
			chk(SCURVE_TIME, es);
			chk(SLIP_SET, ep);
			chk(CARRIER_SET, el ? 8'h14 : 8'h0);
			chk(RELAY_CLOSED, cond(e1));
			chk(OC_CLOSED, cond(e2));
			chk(ACCEL_EFF, ACCEL_TIME + (SCURVE_EN ? es : 12'h0));
			chk(DECEL_EFF, STOP_SCURVE & STOP_CMD ? {DECEL_TIME, 1'h0}
				: DECEL_TIME + (SCURVE_EN ? es : 12'h0));
			chk(SLIP_ADDER, ((16'(ep) * TORQUE_CURR) >> 8) * 10);
			chk(BOOST_VOLT, boost_exp(UNIT_460V, eb, TORQUE_CURR));
		end
		tally_and_finish;
	end
endmodule
